// [hdl/fskcfg_top.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - one 24-bit word, 48 bits when extended
// - extended half adds freeze, header, length
// - bits 2:0 pick carrier, default 132.5 kHz
// - bits 4:3 baud, bit 5 deviation
// - bit 6 watchdog 1.5 s, on at reset
// - bits 8:7 time-out, default one second
// - bits 10:9 detection time, default 1 ms
// - bit 11 zero-cross sync, bit 14 mains mode
// - codes 00/01 carrier detect, 01 forces clock low, data to host idle level
// - codes 10/11 preamble detect (spi host only, carrier for uart), 11 forces likewise
// - unconditioned codes report detect, lines toggle
// - bits 16:15 clock output, default 4 MHz
// - bit 17 freeze, low active, extended only
// - bit 18 header recognition, extended only
// - bit 19 length count needs 18 and 21
// - bit 21 selects 48-bit word
// - bit 20 header length, default 16 bits
// - bits 39:24 header, reset 9b58
// - bits 47:40 frame length, reset 08
module fskcfg_top #(
	parameter logic [31:0] WD_CYC = fskcfg_pkg::fc_cycles(fskcfg_pkg::FC_WD_US),
	parameter logic [31:0] TOUT1_CYC = fskcfg_pkg::fc_cycles(fskcfg_pkg::FC_TOUT1_US),
	parameter logic [31:0] TOUT3_CYC = fskcfg_pkg::fc_cycles(fskcfg_pkg::FC_TOUT3_US),
	parameter logic [31:0] DET0_CYC = fskcfg_pkg::fc_cycles(fskcfg_pkg::FC_DET0_US),
	parameter logic [31:0] DET1_CYC = fskcfg_pkg::fc_cycles(fskcfg_pkg::FC_DET1_US),
	parameter logic [31:0] DET2_CYC = fskcfg_pkg::fc_cycles(fskcfg_pkg::FC_DET2_US),
	parameter logic [31:0] DET3_CYC = fskcfg_pkg::fc_cycles(fskcfg_pkg::FC_DET3_US)
) (
	input wire logic ref_clk, // 20 MHz clock
	input wire logic rst, // async reset, high
	input wire logic reg_access, // register access window
	input wire logic reg_write, // 1 write, 0 read
	input wire logic ser_tick, // one pulse per bit
	input wire logic ser_din, // write data, msb first
	output logic ser_dout, // read data, msb first
	output logic cfg_wr_err, // last write refused: bad length, or 48 bits with bit 21 clear; cleared when any access starts
	output logic [fskcfg_pkg::FC_W-1:0] cfg_word, // stored word
	input wire logic host_uart, // host type strap
	input wire logic carrier_present, // carrier seen
	input wire logic preamble_present, // preamble seen
	input wire logic pll_locked, // pll lock
	input wire logic rx_clk_raw, // recovered clock
	input wire logic rx_data_raw, // demodulated data
	output logic [2:0] carrier_sel, // carrier code
	output logic [1:0] baud_sel, // baud code
	output logic dev_wide, // deviation 1
	output logic wd_en, // watchdog on
	output logic [31:0] wd_cycles, // watchdog period
	output logic tout_en, // time-out on
	output logic [31:0] tout_cycles, // time-out length
	output logic [31:0] det_cycles, // detect filter time
	output logic zc_sync_en, // zero-cross sync
	output logic mains_async, // async mains mode
	output logic [1:0] clk_out_sel, // clock out code
	output logic clk_out_en, // clock out running
	output logic high_sens, // high sensitivity
	output logic in_filter, // input pre-filter
	output logic freeze_en, // level freeze active
	output logic hdr_en, // header recognition
	output logic hdr_16bit, // 16-bit header
	output logic flen_en, // frame length count
	output logic [15:0] frame_header, // header pattern
	output logic [7:0] frame_len, // words per frame
	output logic rx_tx_bit_clock, // conditioned clock
	output logic rx_data_out, // conditioned data
	output logic carrier_detect_out_n // detect, low active
);
	import fskcfg_pkg::*;

	fskcfg_state_t state_q;
	logic [FC_W-1:0] cfg_q;
	logic [FC_W-1:0] shift_q;
	logic [5:0] cnt_q;
	logic err_q;
	logic start;
	logic commit;
	logic good24;
	logic good48;

	function automatic logic is_ext(input logic [FC_W-1:0] w);
		is_ext = w[FC_EXT];
	endfunction

	assign start = state_q == FC_IDLE && reg_access;
	assign commit = state_q == FC_WR && !reg_access;
	assign good24 = cnt_q == FC_LEN_SHORT;
	// a long write only lands if it turns the extended word on
	assign good48 = cnt_q == FC_LEN_LONG && is_ext(shift_q);
	assign cfg_word = cfg_q;
	assign ser_dout = shift_q[FC_W-1];
	assign cfg_wr_err = err_q;

	////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= FC_IDLE;
		end else begin
			case (state_q)
				FC_IDLE: begin
					if (reg_access) begin
						state_q <= reg_write ? FC_WR : FC_RD;
					end
				end
				default: begin
					if (!reg_access) begin
						state_q <= FC_IDLE;
					end
				end
			endcase
		end
	end

	// read image sits msb-aligned so the short word leaves first bit first
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			shift_q <= '0;
			cnt_q <= '0;
		end else if (start) begin
			cnt_q <= '0;
			if (reg_write) begin
				shift_q <= '0;
			end else if (is_ext(cfg_q)) begin
				shift_q <= cfg_q;
			end else begin
				shift_q <= {cfg_q[FC_LOW_W-1:0], {FC_LOW_W{1'b0}}};
			end
		end else if (reg_access && ser_tick) begin
			if (state_q == FC_WR) begin
				shift_q <= {shift_q[FC_W-2:0], ser_din};
				// saturate so overlong writes never alias to a legal length
				if (cnt_q != FC_LEN_OVER) begin
					cnt_q <= cnt_q + 6'h01;
				end
			end else begin
				shift_q <= {shift_q[FC_W-2:0], 1'b0};
			end
		end
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cfg_q <= FC_CFG_RST;
		end else if (commit) begin
			if (good48) begin
				cfg_q <= shift_q;
			end else if (good24) begin
				cfg_q[FC_LOW_W-1:0] <= shift_q[FC_LOW_W-1:0];
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			err_q <= 1'b0;
		end else if (commit) begin
			err_q <= !(good24 || good48);
		end else if (start) begin
			err_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	fskcfg_dec #(
		.WD_CYC(WD_CYC),
		.TOUT1_CYC(TOUT1_CYC),
		.TOUT3_CYC(TOUT3_CYC),
		.DET0_CYC(DET0_CYC),
		.DET1_CYC(DET1_CYC),
		.DET2_CYC(DET2_CYC),
		.DET3_CYC(DET3_CYC)
	) u_dec (
		.ref_clk(ref_clk),
		.rst(rst),
		.cfg(cfg_q),
		.host_uart(host_uart),
		.carrier_present(carrier_present),
		.preamble_present(preamble_present),
		.pll_locked(pll_locked),
		.rx_clk_raw(rx_clk_raw),
		.rx_data_raw(rx_data_raw),
		.carrier_sel(carrier_sel),
		.baud_sel(baud_sel),
		.dev_wide(dev_wide),
		.wd_en(wd_en),
		.wd_cycles(wd_cycles),
		.tout_en(tout_en),
		.tout_cycles(tout_cycles),
		.det_cycles(det_cycles),
		.zc_sync_en(zc_sync_en),
		.mains_async(mains_async),
		.clk_out_sel(clk_out_sel),
		.clk_out_en(clk_out_en),
		.high_sens(high_sens),
		.in_filter(in_filter),
		.freeze_en(freeze_en),
		.hdr_en(hdr_en),
		.hdr_16bit(hdr_16bit),
		.flen_en(flen_en),
		.frame_header(frame_header),
		.frame_len(frame_len),
		.rx_tx_bit_clock(rx_tx_bit_clock),
		.rx_data_out(rx_data_out),
		.carrier_detect_out_n(carrier_detect_out_n)
	);

	////////////////////////////////////////////////////////////////
	property p_reset_default;
		@(posedge ref_clk) $fell(rst) |-> cfg_q == FC_CFG_RST && wd_en && tout_en;
	endproperty
	a_reset_default: assert property (p_reset_default) else $error("defaults not loaded");

	property p_short_commit;
		@(posedge ref_clk) disable iff (rst)
		commit && good24 |=> cfg_q[FC_LOW_W-1:0] == $past(shift_q[FC_LOW_W-1:0])
			&& cfg_q[FC_W-1:FC_LOW_W] == $past(cfg_q[FC_W-1:FC_LOW_W]) && !err_q;
	endproperty
	a_short_commit: assert property (p_short_commit) else $error("short write wrong");

	property p_long_commit;
		@(posedge ref_clk) disable iff (rst)
		commit && cnt_q == FC_LEN_LONG && shift_q[FC_EXT] |=> cfg_q == $past(shift_q) && cfg_q[FC_EXT];
	endproperty
	a_long_commit: assert property (p_long_commit) else $error("long write wrong");

	property p_long_needs_ext;
		@(posedge ref_clk) disable iff (rst)
		commit && cnt_q == FC_LEN_LONG && !shift_q[FC_EXT] |=> $stable(cfg_q) && err_q;
	endproperty
	a_long_needs_ext: assert property (p_long_needs_ext) else $error("long write without ext");

	property p_idle_hold;
		@(posedge ref_clk) disable iff (rst)
		state_q != FC_WR ##1 state_q != FC_WR |-> $stable(cfg_q);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("word changed without write");

	property p_ext_gate;
		@(posedge ref_clk) disable iff (rst)
		!cfg_q[FC_EXT] |=> !hdr_en && !flen_en && !freeze_en && !hdr_16bit;
	endproperty
	a_ext_gate: assert property (p_ext_gate) else $error("extended function live");

	property p_flen;
		@(posedge ref_clk) disable iff (rst)
		cfg_q[FC_EXT] && cfg_q[FC_HDR_EN] && cfg_q[FC_FLEN_EN] ##1 !$past(rst) |-> flen_en && hdr_en;
	endproperty
	a_flen: assert property (p_flen) else $error("length count not active");

	property p_freeze;
		@(posedge ref_clk) disable iff (rst)
		cfg_q[FC_EXT] && !cfg_q[FC_FRZ_OFF] |=> freeze_en;
	endproperty
	a_freeze: assert property (p_freeze) else $error("freeze not active");

	property p_tout3;
		@(posedge ref_clk) disable iff (rst)
		cfg_q[FC_TOUT_LO +: 2] == FC_TOUT_3S |=> tout_en && tout_cycles == TOUT3_CYC;
	endproperty
	a_tout3: assert property (p_tout3) else $error("3 s time-out wrong");

	property p_det5;
		@(posedge ref_clk) disable iff (rst)
		cfg_q[FC_DET_LO +: 2] == 2'h3 |=> det_cycles == DET3_CYC;
	endproperty
	a_det5: assert property (p_det5) else $error("5 ms detect wrong");

	property p_cond_carrier;
		@(posedge ref_clk) disable iff (rst)
		!host_uart && cfg_q[FC_METH_LO +: 2] == 2'h1 && !carrier_present
			|=> !rx_tx_bit_clock && !rx_data_out && carrier_detect_out_n;
	endproperty
	a_cond_carrier: assert property (p_cond_carrier) else $error("carrier conditioning wrong");

	property p_free_preamble;
		@(posedge ref_clk) disable iff (rst)
		!host_uart && cfg_q[FC_METH_LO +: 2] == 2'h2 && preamble_present && pll_locked
			|=> rx_tx_bit_clock == $past(rx_clk_raw) && !carrier_detect_out_n;
	endproperty
	a_free_preamble: assert property (p_free_preamble) else $error("preamble report wrong");

	property p_clkout;
		@(posedge ref_clk) disable iff (rst)
		cfg_q[FC_CLKO_LO +: 2] == FC_CLKO_OFF |=> !clk_out_en && clk_out_sel == FC_CLKO_OFF;
	endproperty
	a_clkout: assert property (p_clkout) else $error("clock out not off");

	// judged on the raw count so a broken length compare still shows
	property p_bad_len;
		@(posedge ref_clk) disable iff (rst)
		commit && cnt_q != FC_LEN_SHORT && cnt_q != FC_LEN_LONG |=> $stable(cfg_q) && err_q;
	endproperty
	a_bad_len: assert property (p_bad_len) else $error("bad length accepted");

	property p_free_carrier;
		@(posedge ref_clk) disable iff (rst)
		!host_uart && cfg_q[FC_METH_LO +: 2] == 2'h0 && carrier_present
			|=> rx_tx_bit_clock == $past(rx_clk_raw) && rx_data_out == $past(rx_data_raw) && !carrier_detect_out_n;
	endproperty
	a_free_carrier: assert property (p_free_carrier) else $error("carrier report wrong");

	property p_cond_unlock;
		@(posedge ref_clk) disable iff (rst)
		!host_uart && cfg_q[FC_METH_LO +: 2] == 2'h3 && !pll_locked
			|=> !rx_tx_bit_clock && !rx_data_out && carrier_detect_out_n;
	endproperty
	a_cond_unlock: assert property (p_cond_unlock) else $error("unlocked preamble not forced");
endmodule

// [hdl/fskcfg_pkg.sv]
package fskcfg_pkg;
	// word layout
	localparam int FC_W = 48;
	localparam int FC_LOW_W = 24;
	localparam logic [5:0] FC_LEN_SHORT = 6'h18;
	localparam logic [5:0] FC_LEN_LONG = 6'h30;
	localparam logic [5:0] FC_LEN_OVER = 6'h31;
	localparam int FC_FREQ_LO = 0;
	localparam int FC_BAUD_LO = 3;
	localparam int FC_DEV = 5;
	localparam int FC_WDOG = 6;
	localparam int FC_TOUT_LO = 7;
	localparam int FC_DET_LO = 9;
	localparam int FC_ZC = 11;
	localparam int FC_METH_LO = 12;
	localparam int FC_MAINS = 14;
	localparam int FC_CLKO_LO = 15;
	localparam int FC_FRZ_OFF = 17;
	localparam int FC_HDR_EN = 18;
	localparam int FC_FLEN_EN = 19;
	localparam int FC_HDR16 = 20;
	localparam int FC_EXT = 21;
	localparam int FC_SENS = 22;
	localparam int FC_FILT = 23;
	localparam int FC_HDR_LO = 24;
	localparam int FC_FLEN_LO = 40;
	// defaults: 132.5 kHz, 2400 Bd, dev 0.5, watchdog on, 1 s time-out, 1 ms detect,
	// preamble without conditioning, async mains, 4 MHz clock out, freeze off, 16-bit header,
	// header 9b58, length 08
	localparam logic [47:0] FC_CFG_RST = 48'h089b581362d7;
	// selector codes
	localparam logic [1:0] FC_TOUT_OFF = 2'h0;
	localparam logic [1:0] FC_TOUT_1S = 2'h1;
	localparam logic [1:0] FC_TOUT_3S = 2'h2;
	localparam logic [1:0] FC_DET_500U = 2'h0;
	localparam logic [1:0] FC_DET_1M = 2'h1;
	localparam logic [1:0] FC_DET_3M = 2'h2;
	localparam logic [1:0] FC_CLKO_OFF = 2'h3;
	// timing
	localparam longint FC_CLK_HZ = 20000000;
	localparam longint FC_WD_US = 1500000;
	localparam longint FC_TOUT1_US = 1000000;
	localparam longint FC_TOUT3_US = 3000000;
	localparam longint FC_DET0_US = 500;
	localparam longint FC_DET1_US = 1000;
	localparam longint FC_DET2_US = 3000;
	localparam longint FC_DET3_US = 5000;
	localparam longint FC_US_PER_S = 1000000;
	// host access sequencer
	typedef enum logic [1:0] {
		FC_IDLE = 2'b00,
		FC_WR = 2'b01,
		FC_RD = 2'b10
	} fskcfg_state_t;

	function automatic logic [31:0] fc_cycles(input longint us);
		fc_cycles = 32'((us * FC_CLK_HZ) / FC_US_PER_S);
	endfunction
endpackage

// [hdl/fskcfg_dec.sv]
`timescale 1ns/1ps
module fskcfg_dec #(
	parameter logic [31:0] WD_CYC = 32'h0,
	parameter logic [31:0] TOUT1_CYC = 32'h0,
	parameter logic [31:0] TOUT3_CYC = 32'h0,
	parameter logic [31:0] DET0_CYC = 32'h0,
	parameter logic [31:0] DET1_CYC = 32'h0,
	parameter logic [31:0] DET2_CYC = 32'h0,
	parameter logic [31:0] DET3_CYC = 32'h0
) (
	input wire logic ref_clk, // system clock
	input wire logic rst, // async reset
	input wire logic [47:0] cfg, // configuration word
	input wire logic host_uart, // 1 uart host, 0 spi host
	input wire logic carrier_present, // carrier seen
	input wire logic preamble_present, // preamble seen
	input wire logic pll_locked, // pll lock
	input wire logic rx_clk_raw, // recovered clock
	input wire logic rx_data_raw, // demodulated data
	output logic [2:0] carrier_sel, // carrier code
	output logic [1:0] baud_sel, // baud code
	output logic dev_wide, // deviation 1
	output logic wd_en, // watchdog on
	output logic [31:0] wd_cycles, // watchdog period
	output logic tout_en, // time-out on
	output logic [31:0] tout_cycles, // time-out length
	output logic [31:0] det_cycles, // detection filter time
	output logic zc_sync_en, // zero-cross sync
	output logic mains_async, // async mains mode
	output logic [1:0] clk_out_sel, // clock out divider
	output logic clk_out_en, // clock out running
	output logic high_sens, // high sensitivity
	output logic in_filter, // input pre-filter
	output logic freeze_en, // level freeze active
	output logic hdr_en, // header recognition active
	output logic hdr_16bit, // 16-bit header
	output logic flen_en, // frame length count active
	output logic [15:0] frame_header, // header pattern
	output logic [7:0] frame_len, // words per frame
	output logic rx_tx_bit_clock, // conditioned bit clock
	output logic rx_data_out, // conditioned data
	output logic carrier_detect_out_n // detect, low active
);
	import fskcfg_pkg::*;

	logic ext;
	logic preamble_mode;
	logic cond;
	logic seen;
	assign ext = cfg[FC_EXT];
	// uart host: 0x codes are carrier modes, 1x not allowed and treated alike
	assign preamble_mode = cfg[FC_METH_LO + 1] & ~host_uart;
	assign cond = cfg[FC_METH_LO];
	assign seen = preamble_mode ? (preamble_present & pll_locked) : carrier_present;

	////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			carrier_sel <= FC_CFG_RST[FC_FREQ_LO +: 3];
			baud_sel <= FC_CFG_RST[FC_BAUD_LO +: 2];
			dev_wide <= FC_CFG_RST[FC_DEV];
			wd_en <= FC_CFG_RST[FC_WDOG];
			zc_sync_en <= FC_CFG_RST[FC_ZC];
			mains_async <= FC_CFG_RST[FC_MAINS];
			clk_out_sel <= FC_CFG_RST[FC_CLKO_LO +: 2];
			clk_out_en <= 1'b1;
			high_sens <= FC_CFG_RST[FC_SENS];
			in_filter <= FC_CFG_RST[FC_FILT];
			frame_header <= FC_CFG_RST[FC_HDR_LO +: 16];
			frame_len <= FC_CFG_RST[FC_FLEN_LO +: 8];
		end else begin
			carrier_sel <= cfg[FC_FREQ_LO +: 3];
			baud_sel <= cfg[FC_BAUD_LO +: 2];
			dev_wide <= cfg[FC_DEV];
			wd_en <= cfg[FC_WDOG];
			zc_sync_en <= cfg[FC_ZC];
			mains_async <= cfg[FC_MAINS];
			clk_out_sel <= cfg[FC_CLKO_LO +: 2];
			clk_out_en <= cfg[FC_CLKO_LO +: 2] != FC_CLKO_OFF;
			high_sens <= cfg[FC_SENS];
			in_filter <= cfg[FC_FILT];
			frame_header <= cfg[FC_HDR_LO +: 16];
			frame_len <= cfg[FC_FLEN_LO +: 8];
		end
	end

	// extended functions are dead while the long word is off
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			freeze_en <= 1'b0;
			hdr_en <= 1'b0;
			hdr_16bit <= 1'b0;
			flen_en <= 1'b0;
		end else begin
			freeze_en <= ext & ~cfg[FC_FRZ_OFF];
			hdr_en <= ext & cfg[FC_HDR_EN];
			hdr_16bit <= ext & cfg[FC_HDR16];
			flen_en <= ext & cfg[FC_HDR_EN] & cfg[FC_FLEN_EN];
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wd_cycles <= WD_CYC;
			tout_en <= 1'b1;
			tout_cycles <= TOUT1_CYC;
			det_cycles <= DET1_CYC;
		end else begin
			wd_cycles <= WD_CYC;
			// unused code 11 falls to disabled
			tout_en <= cfg[FC_TOUT_LO +: 2] == FC_TOUT_1S || cfg[FC_TOUT_LO +: 2] == FC_TOUT_3S;
			tout_cycles <= cfg[FC_TOUT_LO +: 2] == FC_TOUT_3S ? TOUT3_CYC : TOUT1_CYC;
			case (cfg[FC_DET_LO +: 2])
				FC_DET_500U: det_cycles <= DET0_CYC;
				FC_DET_1M: det_cycles <= DET1_CYC;
				FC_DET_3M: det_cycles <= DET2_CYC;
				default: det_cycles <= DET3_CYC;
			endcase
		end
	end

	// conditioning forces clock low and data to the idle level of the host type
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rx_tx_bit_clock <= 1'b0;
			rx_data_out <= 1'b0;
			carrier_detect_out_n <= 1'b1;
		end else begin
			carrier_detect_out_n <= ~seen;
			if (cond && !seen) begin
				rx_tx_bit_clock <= 1'b0;
				rx_data_out <= host_uart;
			end else begin
				rx_tx_bit_clock <= rx_clk_raw;
				rx_data_out <= rx_data_raw;
			end
		end
	end
endmodule

// [tb/fskcfg_host.sv]
`timescale 1ns/1ps
module fskcfg_host (
	input wire logic ref_clk, // system clock
	output logic reg_access, // access window
	output logic reg_write, // 1 write, 0 read
	output logic ser_tick, // bit strobe
	output logic ser_din, // write data
	input wire logic ser_dout // read data
);
	initial begin
		reg_access = 1'b0;
		reg_write = 1'b0;
		ser_tick = 1'b0;
		ser_din = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// one access, msb first; wd holds the low nbits, rd gathers what came back
	task automatic xfer(input logic wr, input int nbits, input logic [47:0] wd, output logic [47:0] rd);
		rd = 48'h0;
		@(negedge ref_clk);
		reg_access = 1'b1;
		reg_write = wr;
		for (int i = nbits - 1; i >= 0; i--) begin
			@(negedge ref_clk);
			ser_tick = 1'b1;
			ser_din = wd[i];
			rd = {rd[46:0], ser_dout};
		end
		@(negedge ref_clk);
		ser_tick = 1'b0;
		reg_access = 1'b0;
		// released line shows the inverse so a stale bit cannot pass
		ser_din = ~ser_din;
		// gap covers commit, word update and decode update
		repeat (3) @(negedge ref_clk);
	endtask
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
	import fskcfg_pkg::*;
	// shortened counts keep the decode checks cheap
	localparam logic [31:0] WD = 32'h1e;
	localparam logic [31:0] T1 = 32'h14;
	localparam logic [31:0] T3 = 32'h3c;
	localparam logic [31:0] DT [4] = '{32'ha, 32'h14, 32'h3c, 32'h64};
	logic ref_clk, rst, reg_access, reg_write, ser_tick, ser_din, ser_dout, cfg_wr_err;
	logic [47:0] cfg_word;
	logic host_uart, carrier_present, preamble_present, pll_locked, rx_clk_raw, rx_data_raw;
	logic [2:0] carrier_sel;
	logic [1:0] baud_sel, clk_out_sel;
	logic dev_wide, wd_en, tout_en, zc_sync_en, mains_async, clk_out_en, high_sens, in_filter;
	logic freeze_en, hdr_en, hdr_16bit, flen_en, rx_tx_bit_clock, rx_data_out, carrier_detect_out_n;
	logic [31:0] wd_cycles, tout_cycles, det_cycles;
	logic [15:0] frame_header;
	logic [7:0] frame_len;
	int err_total = 0;
	int num_checks = 0;
	int cyc = 0;

	fskcfg_top #(.WD_CYC(WD), .TOUT1_CYC(T1), .TOUT3_CYC(T3), .DET0_CYC(DT[0]), .DET1_CYC(DT[1]),
		.DET2_CYC(DT[2]), .DET3_CYC(DT[3])) i_dut (
		.ref_clk, .rst, .reg_access, .reg_write, .ser_tick, .ser_din, .ser_dout, .cfg_wr_err, .cfg_word,
		.host_uart, .carrier_present, .preamble_present, .pll_locked, .rx_clk_raw, .rx_data_raw, .carrier_sel,
		.baud_sel, .dev_wide, .wd_en, .wd_cycles, .tout_en, .tout_cycles, .det_cycles, .zc_sync_en, .mains_async,
		.clk_out_sel, .clk_out_en, .high_sens, .in_filter, .freeze_en, .hdr_en, .hdr_16bit, .flen_en,
		.frame_header, .frame_len, .rx_tx_bit_clock, .rx_data_out, .carrier_detect_out_n);
	fskcfg_host i_host (.ref_clk, .reg_access, .reg_write, .ser_tick, .ser_din, .ser_dout);

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// whole run needs a few thousand cycles
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		logic [47:0] rd;
		check("cfg_word", cfg_word, FC_CFG_RST);
		check("err_dout", 48'({cfg_wr_err, ser_dout}), 48'h0);
		check("carrier", 48'(carrier_sel), 48'h7);
		check("baud_dev", 48'({baud_sel, dev_wide}), 48'h4);
		check("wd", 48'({wd_en, wd_cycles}), 48'({1'b1, WD}));
		check("tout", 48'({tout_en, tout_cycles}), 48'({1'b1, T1}));
		check("det", 48'(det_cycles), 48'(DT[1]));
		check("zc_mains", 48'({zc_sync_en, mains_async}), 48'h1);
		check("clko", 48'({clk_out_en, clk_out_sel}), 48'h6);
		check("ext", 48'({freeze_en, hdr_en, flen_en, hdr_16bit}), 48'h0);
		check("hdr_len", 48'({frame_header, frame_len}), 48'h9b5808);
		check("sens", 48'({high_sens, in_filter}), 48'h0);
		i_host.xfer(1'b0, 24, 48'h0, rd);
		check("read24", rd, 48'(FC_CFG_RST[23:0]));
	endtask
	task automatic t_fields;
		logic [23:0] w;
		logic [1:0] t;
		logic [47:0] rd, hi;
		hi = cfg_word;
		for (int k = 0; k < 8; k++) begin
			logic [2:0] i;
			i = 3'(k);
			t = (i[1:0] == 2'h3) ? 2'h2 : i[1:0];
			w = {i[2], i[1], 1'b0, i[0], i[2], i[1], i[0], i[1:0], i[0], 2'h2, i[2], i[1:0], t, i[1], i[0],
				i[1:0], i};
			i_host.xfer(1'b1, 24, 48'(w), rd);
			check("word24", cfg_word, {hi[47:24], w});
			check("carrier", 48'(carrier_sel), 48'(i));
			check("baud_dev", 48'({baud_sel, dev_wide}), 48'({i[1:0], i[0]}));
			check("wd", 48'(wd_en), 48'(i[1]));
			check("tout_en", 48'(tout_en), 48'(t != 2'h0));
			if (t != 2'h0) check("tout_cyc", 48'(tout_cycles), 48'((t == 2'h2) ? T3 : T1));
			check("det", 48'(det_cycles), 48'(DT[i[1:0]]));
			check("zc_mains", 48'({zc_sync_en, mains_async}), 48'({i[2], i[0]}));
			check("clko", 48'({clk_out_en, clk_out_sel}), 48'({i[1:0] != 2'h3, i[1:0]}));
			check("gated", 48'({freeze_en, hdr_en, flen_en, hdr_16bit}), 48'h0);
			check("sens", 48'({high_sens, in_filter}), 48'({i[1], i[2]}));
			i_host.xfer(1'b0, 24, 48'h0, rd);
			check("read24", rd, 48'(w));
		end
	endtask
	task automatic t_ext;
		logic [47:0] w, rd;
		for (int j = 0; j < 16; j++) begin
			w = {8'(j + 1), 16'ha5c3 ^ 16'(j), 2'h0, 1'b1, 4'(j), FC_CFG_RST[16:0]};
			i_host.xfer(1'b1, 48, w, rd);
			check("word48", cfg_word, w);
			check("freeze", 48'(freeze_en), 48'(!w[17]));
			check("hdr_en", 48'(hdr_en), 48'(w[18]));
			check("flen_en", 48'(flen_en), 48'(w[18] & w[19]));
			check("hdr16", 48'(hdr_16bit), 48'(w[20]));
			check("header", 48'(frame_header), 48'(w[39:24]));
			check("len", 48'(frame_len), 48'(w[47:40]));
			i_host.xfer(1'b0, 48, 48'h0, rd);
			check("read48", rd, w);
		end
	endtask
	task automatic t_refuse;
		logic [47:0] rd, keep;
		int n [4] = '{23, 25, 47, 48};
		keep = cfg_word;
		// the 48-bit case carries bit 21 clear and must be refused too
		for (int k = 0; k < 4; k++) begin
			i_host.xfer(1'b1, n[k], 48'h0, rd);
			check("wr_err", 48'(cfg_wr_err), 48'h1);
			check("kept", cfg_word, keep);
		end
		i_host.xfer(1'b1, 24, 48'(FC_CFG_RST[23:0]), rd);
		check("wr_ok_err", 48'(cfg_wr_err), 48'h0);
		check("wr_ok", cfg_word, {keep[47:24], FC_CFG_RST[23:0]});
		check("gated", 48'({freeze_en, hdr_en, flen_en, hdr_16bit}), 48'h0);
	endtask
	task automatic t_rx;
		logic [47:0] rd;
		logic [1:0] m;
		logic p, v, frc;
		for (int k = 0; k < 16; k++) begin
			m = 2'(k >> 2);
			p = k[1];
			v = k[0];
			if (k % 4 == 0) i_host.xfer(1'b1, 24, 48'({FC_CFG_RST[23:14], m, FC_CFG_RST[11:0]}), rd);
			// the unused detect source disagrees, so a wrong source shows
			carrier_present = p ^ m[1];
			preamble_present = p ^ !m[1];
			pll_locked = 1'b1;
			rx_clk_raw = v;
			rx_data_raw = !v;
			repeat (2) @(negedge ref_clk);
			frc = m[0] & !p;
			check("cd_n", 48'(carrier_detect_out_n), 48'(!p));
			check("rx_clk", 48'(rx_tx_bit_clock), 48'(v & !frc));
			check("rx_data", 48'(rx_data_out), 48'(!v & !frc));
		end
		preamble_present = 1'b1;
		pll_locked = 1'b0;
		repeat (2) @(negedge ref_clk);
		check("unlock", 48'({carrier_detect_out_n, rx_tx_bit_clock, rx_data_out}), 48'h4);
		host_uart = 1'b1;
		carrier_present = 1'b0;
		repeat (2) @(negedge ref_clk);
		check("uart_idle", 48'({carrier_detect_out_n, rx_tx_bit_clock, rx_data_out}), 48'h5);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		host_uart = 1'b0;
		carrier_present = 1'b0;
		preamble_present = 1'b0;
		pll_locked = 1'b0;
		rx_clk_raw = 1'b0;
		rx_data_raw = 1'b0;
		repeat (20) @(negedge ref_clk);
		rst = 1'b0;
		@(negedge ref_clk);
		t_reset();
		t_fields();
		t_ext();
		t_refuse();
		t_rx();
		rst = 1'b1;
		repeat (2) @(negedge ref_clk);
		check("rereset", cfg_word, FC_CFG_RST);
		rst = 1'b0;
		repeat (2) @(negedge ref_clk);
		check("rereset_dec", 48'({carrier_sel, baud_sel, wd_en, tout_en, clk_out_en, cfg_wr_err}), 48'({3'h7, 2'h2, 4'he}));
		check("rereset_rx", 48'({carrier_detect_out_n, rx_tx_bit_clock, rx_data_out}), 48'h6);
		summarize();
	end
endmodule
